// File: core/bus_cycle_pkg.sv
/*
  shared constants for the machine cycle sequencer: cycle kinds, opcode
  patterns, state counts, reset values.
  assumes one clock, every state lasting one clock period.
*/
package bus_cycle_pkg;

  typedef enum logic [2:0] {
    CYC_NONE,
    CYC_FETCH_FIRST,
    CYC_FETCH_LATER,
    CYC_READ,
    CYC_WRITE
  } cycle_kind_t;

  localparam logic [15:0] PC_RESET      = 16'h0000;
  localparam logic [1:0]  BUS_LAST_T    = 2'h2;
  localparam logic [2:0]  ADD16_IDLES   = 3'h4;
  localparam logic [2:0]  ALU_REG_IDLES = 3'h1;
  localparam logic [2:0]  INDEX_IDLES   = 3'h3;
  localparam logic [2:0]  CALL_IDLES    = 3'h1;

  localparam logic [7:0] OP_PFX_X    = 8'hDD;
  localparam logic [7:0] OP_PFX_Y    = 8'hFD;
  localparam logic [7:0] OP_PFX_ED   = 8'hED;
  localparam logic [7:0] OP_PFX_BIT  = 8'hCB;
  localparam logic [7:0] OP_CALL     = 8'hCD;
  localparam logic [7:0] PAIR_MASK   = 8'hCF;
  localparam logic [7:0] OP_ADD16    = 8'h09;
  localparam logic [7:0] OP_ADC16    = 8'h4A;
  localparam logic [7:0] OP_SBC16    = 8'h42;
  localparam logic [1:0] GRP_ALU     = 2'h2;
  localparam logic [1:0] GRP_BIT     = 2'h1;
  localparam logic [1:0] GRP_MISC    = 2'h3;
  localparam logic [2:0] SRC_MEM     = 3'h6;
  localparam logic [2:0] SUB_CALLCC  = 3'h4;

  localparam int FLAG_SIGN  = 7;
  localparam int FLAG_ZERO  = 6;
  localparam int FLAG_PAR   = 2;
  localparam int FLAG_CARRY = 0;

endpackage

// File: core/bus_pin_driver.sv
/*
  registers the processor bus pins from the cycle kind chosen for the next state.
  assumes the kind, address and write byte arrive one clock before they show.
*/
`timescale 1ns/1ps
`default_nettype none

module bus_pin_driver (
  input  wire logic                      clk,
  input  wire logic                      rst,
  input  wire bus_cycle_pkg::cycle_kind_t kind_nxt,
  input  wire logic [15:0]               addr_nxt,
  input  wire logic [7:0]                wdata_nxt,
  output logic      [15:0]               address,
  output logic      [7:0]                data_out,
  output logic                           data_oe,
  output logic                           read_n,
  output logic                           write_n,
  output logic                           memory_request_n,
  output logic                           io_request_n,
  output logic                           fetch_marker_n,
  output logic                           halt_n,
  output logic                           status_line
);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      address          <= 16'h0000;
      data_out         <= 8'h00;
      data_oe          <= 1'b0;
      read_n           <= 1'b1;
      write_n          <= 1'b1;
      memory_request_n <= 1'b1;
      io_request_n     <= 1'b1;
      fetch_marker_n   <= 1'b1;
      halt_n           <= 1'b1;
      status_line      <= 1'b1;
    end else begin
      address          <= addr_nxt;
      data_out         <= wdata_nxt;
      data_oe          <= (kind_nxt == bus_cycle_pkg::CYC_WRITE);
      read_n           <= !(kind_nxt == bus_cycle_pkg::CYC_FETCH_FIRST ||
                            kind_nxt == bus_cycle_pkg::CYC_FETCH_LATER ||
                            kind_nxt == bus_cycle_pkg::CYC_READ);
      write_n          <= (kind_nxt != bus_cycle_pkg::CYC_WRITE);
      memory_request_n <= (kind_nxt == bus_cycle_pkg::CYC_NONE);
      io_request_n     <= 1'b1;
      halt_n           <= 1'b1;
      fetch_marker_n   <= !(kind_nxt == bus_cycle_pkg::CYC_FETCH_FIRST ||
                            kind_nxt == bus_cycle_pkg::CYC_FETCH_LATER);
      status_line      <= (kind_nxt != bus_cycle_pkg::CYC_FETCH_FIRST);
    end
  end

endmodule // bus_pin_driver

`default_nettype wire

// File: core/cpu_bus_cycle_sequencer.sv
/*
  machine cycle sequencer: fetches opcodes, classifies arithmetic, bit test and
  call instructions, and steps their fetch, read, write and idle cycles.
  assumes memory answers within the three clocks of a bus cycle on this clock,
  and register values at the inputs are stable while an instruction runs.
*/
`timescale 1ns/1ps
`default_nettype none

// Operation
// - first fetch: read, request, marker, status low
// - second opcode fetch drives status high
// - idle states: strobes high, data released
// - sixteen-bit pair add: fetches then four idles
// - register accumulator op: fetch, one idle
// - immediate accumulator op reads next byte
// - pointer accumulator op reads at pointer
// - indexed op reads displacement third cycle
// - indexed op: three idles, then indexed read
// - indexed bit test fetches third opcode
// - indexed bit test ends with indexed read
// - operand reads keep marker and status high
// - call target: low byte then high byte
// - false conditional call ends after two cycles
// - taken call pushes return address high, low
module cpu_bus_cycle_sequencer (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        run,
  input  wire logic [7:0]  data_in,
  input  wire logic [7:0]  flags,
  input  wire logic [15:0] memory_pointer_pair,
  input  wire logic [15:0] index_x,
  input  wire logic [15:0] index_y,
  input  wire logic [15:0] stack_pointer,
  output logic      [15:0] address,
  output logic      [7:0]  data_out,
  output logic             data_oe,
  output logic             read_n,
  output logic             write_n,
  output logic             memory_request_n,
  output logic             io_request_n,
  output logic             fetch_marker_n,
  output logic             halt_n,
  output logic             status_line,
  output logic      [15:0] program_counter,
  output logic             instr_done
);

  typedef enum logic [3:0] {
    S_STOPPED,
    S_FETCH1,
    S_FETCH2,
    S_FETCH3,
    S_DISP,
    S_IMM,
    S_TGT_LO,
    S_TGT_HI,
    S_DATA,
    S_INTERNAL,
    S_PUSH_HI,
    S_PUSH_LO
  } seq_state_t;

  function automatic logic cond_true(input logic [2:0] cc, input logic [7:0] f);
    logic bit_v;
    bit_v = 1'b0;
    case (cc[2:1])
      2'h0:    bit_v = f[bus_cycle_pkg::FLAG_ZERO];
      2'h1:    bit_v = f[bus_cycle_pkg::FLAG_CARRY];
      2'h2:    bit_v = f[bus_cycle_pkg::FLAG_PAR];
      default: bit_v = f[bus_cycle_pkg::FLAG_SIGN];
    endcase
    return bit_v == cc[0];
  endfunction

  function automatic logic is_pair_arith(input logic [7:0] b, input logic [7:0] pat);
    return (b & bus_cycle_pkg::PAIR_MASK) == pat;
  endfunction

  function automatic logic is_alu_mem(input logic [7:0] b);
    return b[7:6] == bus_cycle_pkg::GRP_ALU && b[2:0] == bus_cycle_pkg::SRC_MEM;
  endfunction

  seq_state_t  state_r;
  seq_state_t  state_nxt;
  logic [1:0]  t_r;
  logic [1:0]  t_nxt;
  logic [2:0]  idles_r;
  logic [2:0]  idles_nxt;
  logic [15:0] pc_r;
  logic [15:0] pc_nxt;
  logic [7:0]  op1_r;
  logic [7:0]  op1_nxt;
  logic [7:0]  op2_r;
  logic [7:0]  op2_nxt;
  logic [7:0]  disp_r;
  logic [7:0]  disp_nxt;
  logic [7:0]  tgt_lo_r;
  logic [7:0]  tgt_lo_nxt;
  logic [7:0]  tgt_hi_r;
  logic [7:0]  tgt_hi_nxt;
  logic        take_r;
  logic        take_nxt;
  logic        indexed_r;
  logic        indexed_nxt;
  logic        then_data_r;
  logic        then_data_nxt;
  logic        then_push_r;
  logic        then_push_nxt;
  logic        done_r;
  logic        done_nxt;

  logic        cycle_end;
  logic        finish;
  logic [15:0] index_base;
  logic [15:0] index_addr;
  logic [15:0] addr_nxt;
  logic [7:0]  wdata_nxt;
  bus_cycle_pkg::cycle_kind_t kind_nxt;

  assign index_base = (op1_r == bus_cycle_pkg::OP_PFX_Y) ? index_y : index_x;
  assign index_addr = index_base + {{8{disp_nxt[7]}}, disp_nxt};

  always_comb begin
    state_nxt     = state_r;
    t_nxt         = t_r;
    idles_nxt     = idles_r;
    pc_nxt        = pc_r;
    op1_nxt       = op1_r;
    op2_nxt       = op2_r;
    disp_nxt      = disp_r;
    tgt_lo_nxt    = tgt_lo_r;
    tgt_hi_nxt    = tgt_hi_r;
    take_nxt      = take_r;
    indexed_nxt   = indexed_r;
    then_data_nxt = then_data_r;
    then_push_nxt = then_push_r;
    done_nxt      = 1'b0;
    finish        = 1'b0;
    cycle_end     = (state_r == S_INTERNAL) ? (idles_r == 3'h1) : (t_r == bus_cycle_pkg::BUS_LAST_T);
    if (state_r == S_STOPPED) begin
      cycle_end = 1'b0;
      if (run) begin
        state_nxt = S_FETCH1;
      end
    end else if (!cycle_end) begin
      if (state_r == S_INTERNAL) begin
        idles_nxt = idles_r - 3'h1;
      end else begin
        t_nxt = t_r + 2'h1;
      end
    end else begin
      t_nxt = 2'h0;
      case (state_r)
        S_FETCH1: begin
          op1_nxt       = data_in;
          pc_nxt        = pc_r + 16'h0001;
          then_data_nxt = 1'b0;
          then_push_nxt = 1'b0;
          indexed_nxt   = 1'b0;
          if (data_in == bus_cycle_pkg::OP_PFX_X || data_in == bus_cycle_pkg::OP_PFX_Y ||
              data_in == bus_cycle_pkg::OP_PFX_ED || data_in == bus_cycle_pkg::OP_PFX_BIT) begin
            state_nxt = S_FETCH2;
          end else if (is_pair_arith(data_in, bus_cycle_pkg::OP_ADD16)) begin
            state_nxt = S_INTERNAL;
            idles_nxt = bus_cycle_pkg::ADD16_IDLES;
          end else if (is_alu_mem(data_in)) begin
            state_nxt = S_DATA;
          end else if (data_in[7:6] == bus_cycle_pkg::GRP_ALU) begin
            state_nxt = S_INTERNAL;
            idles_nxt = bus_cycle_pkg::ALU_REG_IDLES;
          end else if (data_in[7:6] == bus_cycle_pkg::GRP_MISC && data_in[2:0] == bus_cycle_pkg::SRC_MEM) begin
            state_nxt = S_IMM;
          end else if (data_in == bus_cycle_pkg::OP_CALL) begin
            state_nxt = S_TGT_LO;
            take_nxt  = 1'b1;
          end else if (data_in[7:6] == bus_cycle_pkg::GRP_MISC && data_in[2:0] == bus_cycle_pkg::SUB_CALLCC) begin
            state_nxt = S_TGT_LO;
            take_nxt  = cond_true(data_in[5:3], flags);
          end else begin
            finish = 1'b1;
          end
        end
        S_FETCH2: begin
          op2_nxt = data_in;
          pc_nxt  = pc_r + 16'h0001;
          if (op1_r == bus_cycle_pkg::OP_PFX_BIT) begin
            if (data_in[7:6] == bus_cycle_pkg::GRP_BIT && data_in[2:0] == bus_cycle_pkg::SRC_MEM) begin
              state_nxt = S_DATA;
            end else begin
              finish = 1'b1;
            end
          end else if (op1_r == bus_cycle_pkg::OP_PFX_ED) begin
            if (is_pair_arith(data_in, bus_cycle_pkg::OP_ADC16) ||
                is_pair_arith(data_in, bus_cycle_pkg::OP_SBC16)) begin
              state_nxt = S_INTERNAL;
              idles_nxt = bus_cycle_pkg::ADD16_IDLES;
            end else begin
              finish = 1'b1;
            end
          end else if (is_pair_arith(data_in, bus_cycle_pkg::OP_ADD16)) begin
            state_nxt = S_INTERNAL;
            idles_nxt = bus_cycle_pkg::ADD16_IDLES;
          end else if (is_alu_mem(data_in) || data_in == bus_cycle_pkg::OP_PFX_BIT) begin
            state_nxt = S_DISP;
          end else begin
            finish = 1'b1;
          end
        end
        S_DISP: begin
          disp_nxt    = data_in;
          pc_nxt      = pc_r + 16'h0001;
          indexed_nxt = 1'b1;
          if (op2_r == bus_cycle_pkg::OP_PFX_BIT) begin
            state_nxt = S_FETCH3;
          end else begin
            state_nxt     = S_INTERNAL;
            idles_nxt     = bus_cycle_pkg::INDEX_IDLES;
            then_data_nxt = 1'b1;
          end
        end
        S_FETCH3: begin
          pc_nxt    = pc_r + 16'h0001;
          state_nxt = S_DATA;
        end
        S_IMM: begin
          pc_nxt = pc_r + 16'h0001;
          finish = 1'b1;
        end
        S_TGT_LO: begin
          tgt_lo_nxt = data_in;
          pc_nxt     = take_r ? pc_r + 16'h0001 : pc_r + 16'h0002; // false call skips the unread high byte
          if (take_r) begin
            state_nxt = S_TGT_HI;
          end else begin
            finish = 1'b1;
          end
        end
        S_TGT_HI: begin
          tgt_hi_nxt    = data_in;
          pc_nxt        = pc_r + 16'h0001;
          state_nxt     = S_INTERNAL;
          idles_nxt     = bus_cycle_pkg::CALL_IDLES;
          then_push_nxt = 1'b1;
        end
        S_INTERNAL: begin
          if (then_data_r) begin
            state_nxt = S_DATA;
          end else if (then_push_r) begin
            state_nxt = S_PUSH_HI;
          end else begin
            finish = 1'b1;
          end
        end
        S_PUSH_HI: begin
          state_nxt = S_PUSH_LO;
        end
        S_PUSH_LO: begin
          pc_nxt = {tgt_hi_r, tgt_lo_r};
          finish = 1'b1;
        end
        S_DATA: begin
          finish = 1'b1;
        end
        default: begin
          finish = 1'b1;
        end
      endcase
    end
    if (finish) begin
      done_nxt  = 1'b1;
      state_nxt = run ? S_FETCH1 : S_STOPPED;
    end
  end

  // address and write byte for the state about to be entered; the pin
  // driver registers them so they line up with that state's clocks
  always_comb begin
    kind_nxt  = bus_cycle_pkg::CYC_NONE;
    addr_nxt  = 16'h0000; // idle address carries no meaning
    wdata_nxt = 8'h00;
    case (state_nxt)
      S_FETCH1: begin
        kind_nxt = bus_cycle_pkg::CYC_FETCH_FIRST;
        addr_nxt = pc_nxt;
      end
      S_FETCH2, S_FETCH3: begin
        kind_nxt = bus_cycle_pkg::CYC_FETCH_LATER;
        addr_nxt = pc_nxt;
      end
      S_DISP, S_IMM, S_TGT_LO, S_TGT_HI: begin
        kind_nxt = bus_cycle_pkg::CYC_READ;
        addr_nxt = pc_nxt;
      end
      S_DATA: begin
        kind_nxt = bus_cycle_pkg::CYC_READ;
        addr_nxt = indexed_nxt ? index_addr : memory_pointer_pair;
      end
      S_PUSH_HI: begin
        kind_nxt  = bus_cycle_pkg::CYC_WRITE;
        addr_nxt  = stack_pointer - 16'h0001;
        wdata_nxt = pc_r[15:8];
      end
      S_PUSH_LO: begin
        kind_nxt  = bus_cycle_pkg::CYC_WRITE;
        addr_nxt  = stack_pointer - 16'h0002;
        wdata_nxt = pc_r[7:0];
      end
      default: begin
        kind_nxt = bus_cycle_pkg::CYC_NONE;
      end
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_r     <= S_STOPPED;
      t_r         <= 2'h0;
      idles_r     <= 3'h0;
      pc_r        <= bus_cycle_pkg::PC_RESET;
      op1_r       <= 8'h00;
      op2_r       <= 8'h00;
      disp_r      <= 8'h00;
      tgt_lo_r    <= 8'h00;
      tgt_hi_r    <= 8'h00;
      take_r      <= 1'b0;
      indexed_r   <= 1'b0;
      then_data_r <= 1'b0;
      then_push_r <= 1'b0;
      done_r      <= 1'b0;
    end else begin
      state_r     <= state_nxt;
      t_r         <= t_nxt;
      idles_r     <= idles_nxt;
      pc_r        <= pc_nxt;
      op1_r       <= op1_nxt;
      op2_r       <= op2_nxt;
      disp_r      <= disp_nxt;
      tgt_lo_r    <= tgt_lo_nxt;
      tgt_hi_r    <= tgt_hi_nxt;
      take_r      <= take_nxt;
      indexed_r   <= indexed_nxt;
      then_data_r <= then_data_nxt;
      then_push_r <= then_push_nxt;
      done_r      <= done_nxt;
    end
  end

  assign program_counter = pc_r;
  assign instr_done      = done_r;

  bus_pin_driver u_pins (
    .clk              (clk),
    .rst              (rst),
    .kind_nxt         (kind_nxt),
    .addr_nxt         (addr_nxt),
    .wdata_nxt        (wdata_nxt),
    .address          (address),
    .data_out         (data_out),
    .data_oe          (data_oe),
    .read_n           (read_n),
    .write_n          (write_n),
    .memory_request_n (memory_request_n),
    .io_request_n     (io_request_n),
    .fetch_marker_n   (fetch_marker_n),
    .halt_n           (halt_n),
    .status_line      (status_line)
  );

endmodule // cpu_bus_cycle_sequencer

`default_nettype wire

// File: testbench/bus_memory_model.sv
/*
  external memory on the processor bus: answers reads, takes writes.
  assumes reads have no wait states; the bench loads code through mem.
*/
`timescale 1ns/1ps
`default_nettype none

module bus_memory_model (
  input  wire logic        clk,
  input  wire logic [15:0] address,
  input  wire logic [7:0]  data_out,
  input  wire logic        data_oe,
  input  wire logic        read_n,
  input  wire logic        write_n,
  input  wire logic        memory_request_n,
  output logic      [7:0]  data_in
);
  logic [7:0] mem [0:65535];
  logic [7:0] last_r;

  initial begin
    for (int i = 0; i < 65536; i++) mem[i] = 8'h00;
    last_r = 8'h00;
  end

  // released bus shows the inverse of the last byte, so a stale sample cannot pass
  always_comb begin
    if (!read_n && !memory_request_n) data_in = mem[address];
    else data_in = ~last_r;
  end

  always @(posedge clk) begin
    if (!read_n && !memory_request_n) last_r <= mem[address];
    if (!write_n && !memory_request_n && data_oe) mem[address] <= data_out;
  end
endmodule // bus_memory_model

`default_nettype wire

// File: testbench/cpu_bus_cycle_sequencer_bench.sv
/*
  self-checking bench: runs one program and checks every bus state.
  assumes pins show the first fetch from the first edge after reset release.
*/
`timescale 1ns/1ps
`default_nettype none

module cpu_bus_cycle_sequencer_bench;
  localparam logic [6:0] P_F1 = 7'h2A;
  localparam logic [6:0] P_F2 = 7'h2B;
  localparam logic [6:0] P_RD = 7'h2F;
  localparam logic [6:0] P_WR = 7'h4F;
  localparam logic [6:0] P_ID = 7'h7F;
  localparam logic [15:0] SP = 16'h4000;

  logic        clk;
  logic        rst;
  logic        run;
  logic [7:0]  data_in;
  logic [7:0]  flags;
  logic [15:0] address;
  logic [7:0]  data_out;
  logic        data_oe;
  logic        read_n;
  logic        write_n;
  logic        memory_request_n;
  logic        io_request_n;
  logic        fetch_marker_n;
  logic        halt_n;
  logic        status_line;
  logic [15:0] program_counter;
  logic        instr_done;
  logic [6:0]  pins;
  int          err_total;
  int          checks_done;
  logic [7:0]  prog [0:21] = '{8'h09, 8'hDD, 8'h09, 8'hED, 8'h4A, 8'h80, 8'hFE, 8'h55, 8'h86, 8'hDD, 8'h86,
                               8'hFE, 8'hFD, 8'hCB, 8'h05, 8'h46, 8'hC4, 8'h00, 8'h50, 8'hCD, 8'h00, 8'h60};

  assign pins = {read_n, write_n, memory_request_n, io_request_n, fetch_marker_n, halt_n, status_line};

  cpu_bus_cycle_sequencer cpu_bus_cycle_sequencer_i (
    .clk(clk), .rst(rst), .run(run), .data_in(data_in), .flags(flags),
    .memory_pointer_pair(16'h1234), .index_x(16'h2000), .index_y(16'h3000), .stack_pointer(SP),
    .address(address), .data_out(data_out), .data_oe(data_oe), .read_n(read_n), .write_n(write_n),
    .memory_request_n(memory_request_n), .io_request_n(io_request_n), .fetch_marker_n(fetch_marker_n),
    .halt_n(halt_n), .status_line(status_line), .program_counter(program_counter), .instr_done(instr_done));

  bus_memory_model bus_memory_model_i (
    .clk(clk), .address(address), .data_out(data_out), .data_oe(data_oe), .read_n(read_n),
    .write_n(write_n), .memory_request_n(memory_request_n), .data_in(data_in));

  always #50 clk = ~clk;

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // one bus cycle, three states; address and strobes must hold throughout
  task automatic mc(input logic [6:0] p, input logic [15:0] a, input logic [7:0] d);
    for (int k = 0; k < 3; k++) begin
      @(negedge clk);
      check("pins", {9'h000, pins}, {9'h000, p});
      check("address", address, a);
      check("data_oe", {15'h0000, data_oe}, {15'h0000, p == P_WR});
      if (p == P_WR) check("data_out", {8'h00, data_out}, {8'h00, d});
      // done pulses only in the first clock of a fetch that follows a finished instruction
      check("instr_done", {15'h0000, instr_done}, {15'h0000, (k == 0 && p == P_F1 && a != 16'h0000)});
      if (p == P_F1) check("program_counter", program_counter, a);
    end
  endtask

  task automatic idl(input int n);
    repeat (n) begin
      @(negedge clk);
      check("idle pins", {9'h000, pins}, {9'h000, P_ID});
      check("idle data_oe", {15'h0000, data_oe}, 16'h0000);
      check("idle instr_done", {15'h0000, instr_done}, 16'h0000);
    end
  endtask

  task automatic t_add16;
    mc(P_F1, 16'h0000, 8'h00);
    idl(4);
    mc(P_F1, 16'h0001, 8'h00);
    mc(P_F2, 16'h0002, 8'h00);
    idl(4);
    mc(P_F1, 16'h0003, 8'h00);
    mc(P_F2, 16'h0004, 8'h00);
    idl(4);
    $display("test add16 done");
  endtask

  task automatic t_alu;
    mc(P_F1, 16'h0005, 8'h00);
    idl(1);
    mc(P_F1, 16'h0006, 8'h00);
    mc(P_RD, 16'h0007, 8'h00);
    mc(P_F1, 16'h0008, 8'h00);
    mc(P_RD, 16'h1234, 8'h00);
    $display("test alu done");
  endtask

  // negative displacement checks sign extension of the offset
  task automatic t_indexed;
    mc(P_F1, 16'h0009, 8'h00);
    mc(P_F2, 16'h000A, 8'h00);
    mc(P_RD, 16'h000B, 8'h00);
    idl(3);
    mc(P_RD, 16'h1FFE, 8'h00);
    mc(P_F1, 16'h000C, 8'h00);
    mc(P_F2, 16'h000D, 8'h00);
    mc(P_RD, 16'h000E, 8'h00);
    mc(P_F2, 16'h000F, 8'h00);
    mc(P_RD, 16'h3005, 8'h00);
    $display("test indexed done");
  endtask

  task automatic t_call(input logic [15:0] pc, input logic [7:0] fl, input logic taken);
    logic [15:0] ret;
    ret = pc + 16'h0003;
    flags = fl;
    mc(P_F1, pc, 8'h00);
    mc(P_RD, pc + 16'h0001, 8'h00);
    if (taken) begin
      mc(P_RD, pc + 16'h0002, 8'h00);
      idl(1);
      mc(P_WR, SP - 16'h0001, ret[15:8]);
      mc(P_WR, SP - 16'h0002, ret[7:0]);
      check("stack high", {8'h00, bus_memory_model_i.mem[SP - 16'h0001]}, {8'h00, ret[15:8]});
      check("stack low", {8'h00, bus_memory_model_i.mem[SP - 16'h0002]}, {8'h00, ret[7:0]});
    end
    $display("test call at %h done", pc);
  endtask

  task automatic complete_run;
    $display("checks %0d errors %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  initial begin
    clk = 1'b0;
    rst = 1'b1;
    run = 1'b1;
    flags = 8'h00;
    err_total = 0;
    checks_done = 0;
    @(negedge clk);
    for (int i = 0; i < 22; i++) bus_memory_model_i.mem[i] = prog[i];
    bus_memory_model_i.mem[16'h6000] = 8'hC4;
    bus_memory_model_i.mem[16'h6001] = 8'h34;
    bus_memory_model_i.mem[16'h6002] = 8'h70;
    bus_memory_model_i.mem[16'h7034] = 8'h80;
    bus_memory_model_i.mem[16'h7035] = 8'hCB;
    bus_memory_model_i.mem[16'h7036] = 8'h46;
    bus_memory_model_i.mem[16'h7037] = 8'hED;
    bus_memory_model_i.mem[16'h7038] = 8'h42;
    repeat (4) @(negedge clk);
    rst = 1'b0;
    @(posedge clk);
    t_add16();
    t_alu();
    t_indexed();
    t_call(16'h0010, 8'h40, 1'b0);
    t_call(16'h0013, 8'h40, 1'b1);
    t_call(16'h6000, 8'h00, 1'b1);
    mc(P_F1, 16'h7034, 8'h00);
    idl(1);
    mc(P_F1, 16'h7035, 8'h00);
    mc(P_F2, 16'h7036, 8'h00);
    mc(P_RD, 16'h1234, 8'h00);
    mc(P_F1, 16'h7037, 8'h00);
    mc(P_F2, 16'h7038, 8'h00);
    idl(4);
    $display("test bit and subtract done");
    complete_run();
  end

  // the program needs about 135 clocks
  initial begin
    repeat (2000) @(posedge clk);
    err_total++;
    complete_run();
  end
endmodule // cpu_bus_cycle_sequencer_bench

`default_nettype wire

// File: testbench/cpu_bus_cycle_sequencer_checker.sv
/*
  concurrent checks on the sequencer's bus pins.
  assumes one clock and the asynchronous active-high reset of the design.
*/
`timescale 1ns/1ps
`default_nettype none

module cpu_bus_cycle_sequencer_checker (
  input wire logic        clk,
  input wire logic        rst,
  input wire logic [15:0] address,
  input wire logic        data_oe,
  input wire logic        read_n,
  input wire logic        write_n,
  input wire logic        memory_request_n,
  input wire logic        io_request_n,
  input wire logic        fetch_marker_n,
  input wire logic        halt_n,
  input wire logic        status_line,
  input wire logic [15:0] stack_pointer,
  input wire logic        instr_done
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  a_first_fetch_pins: assert property ($fell(status_line) |->
    (!status_line && !fetch_marker_n && !read_n && !memory_request_n && write_n)[*3])
    else $error("first fetch pins wrong");
  a_later_fetch_pins: assert property (!fetch_marker_n && status_line |-> !read_n && !memory_request_n)
    else $error("later fetch pins wrong");
  a_idle_all_high: assert property (read_n && write_n |->
    memory_request_n && fetch_marker_n && status_line && !data_oe)
    else $error("idle state not released");
  a_no_io_halt: assert property (io_request_n && halt_n)
    else $error("io request or halt active");
  a_operand_marker: assert property (!read_n && fetch_marker_n |-> status_line && !memory_request_n)
    else $error("operand read marker or status wrong");
  a_bus_addr_stable: assert property ($fell(memory_request_n) |=>
    ($stable(address) && !memory_request_n)[*2])
    else $error("bus cycle address not held");
  a_write_strobes: assert property (!write_n |-> data_oe && !memory_request_n && read_n && fetch_marker_n)
    else $error("write cycle strobes wrong");
  a_push_high_first: assert property ($fell(write_n) |->
    address == stack_pointer - 16'h0001 ##3 (!write_n && address == stack_pointer - 16'h0002))
    else $error("push order or address wrong");
  a_done_next_fetch: assert property (instr_done |-> !status_line ##1 !instr_done)
    else $error("done not followed by fetch");

  c_push: cover property ($fell(write_n));
  c_idle: cover property (read_n && write_n);
  c_later_fetch: cover property (!fetch_marker_n && status_line);
endmodule // cpu_bus_cycle_sequencer_checker

bind cpu_bus_cycle_sequencer cpu_bus_cycle_sequencer_checker cpu_bus_cycle_sequencer_checker_i (
  .clk(clk), .rst(rst), .address(address), .data_oe(data_oe), .read_n(read_n), .write_n(write_n),
  .memory_request_n(memory_request_n), .io_request_n(io_request_n), .fetch_marker_n(fetch_marker_n),
  .halt_n(halt_n), .status_line(status_line), .stack_pointer(stack_pointer), .instr_done(instr_done));

`default_nettype wire
